// file: logic/ccs_pkg.sv
// package: register layout, reset values and types of the crc control and status block
package ccs_pkg;

  // ----------------------------------------------------------------
  // register map (word addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] CCS_ADDR_CTRL1   = 4'h0;  // crc_control_one
  localparam logic [3:0] CCS_ADDR_POLY_LENGTH_FIELD    = 4'h1;  // poly_length_field holder
  localparam logic [3:0] CCS_ADDR_DATA    = 4'h2;  // input_word_reg (write pushes fifo)
  localparam logic [3:0] CCS_ADDR_RESULT  = 4'h3;  // result_word_reg
  localparam logic [3:0] CCS_ADDR_IRQ_ST  = 4'h4;  // sticky event status, write one to clear
  localparam logic [3:0] CCS_ADDR_IRQ_MSK = 4'h5;  // event mask, one enables

  // ----------------------------------------------------------------
  // crc_control_one field positions
  // ----------------------------------------------------------------
  localparam int CCS_BIT_UNIT_ON   = 15;
  localparam int CCS_BIT_HALT_IDLE = 13;
  localparam int CCS_BIT_CNT_HI    = 12;
  localparam int CCS_BIT_CNT_LO    = 8;
  localparam int CCS_BIT_FULL      = 7;
  localparam int CCS_BIT_EMPTY     = 6;
  localparam int CCS_BIT_IRQ_SEL   = 5;
  localparam int CCS_BIT_RUN       = 4;
  localparam int CCS_BIT_LSB_FIRST = 3;

  // ----------------------------------------------------------------
  // sizes, thresholds and reset values
  // ----------------------------------------------------------------
  localparam int          CCS_DW          = 16;     // data word width
  localparam int          CCS_DEPTH       = 16;     // physical fifo depth
  localparam logic [4:0]  CCS_DEPTH_LONG  = 5'h10;  // words when length field <= 7
  localparam logic [4:0]  CCS_DEPTH_SHORT = 5'h08;  // words when length field > 7
  localparam logic [4:0]  CCS_POLY_LENGTH_FIELD_SPLIT  = 5'h07;
  localparam logic [4:0]  CCS_SHIFT_LAST  = 5'h0F;  // bit index of last shift of a word
  localparam logic [15:0] CCS_RST_CTRL    = 16'h0000;
  localparam logic [4:0]  CCS_RST_POLY_LENGTH_FIELD    = 5'h0F;
  localparam logic [1:0]  CCS_RST_IRQ     = 2'h0;
  localparam int          CCS_EV_EMPTY    = 0;      // status bit: fifo went empty
  localparam int          CCS_EV_DONE     = 1;      // status bit: shifting finished

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       unit_on;
    logic       halt_in_idle;
    logic       irq_source_select;
    logic       shifter_run;
    logic       lsb_first_select;
  } ccs_ctrl_t;

  typedef struct packed {
    logic [4:0] fifo_word_count;
    logic       fifo_full_flag;
    logic       fifo_empty_flag;
  } ccs_fifo_stat_t;

  typedef enum logic [2:0] {
    CCS_ST_IDLE  = 3'b001,
    CCS_ST_SHIFT = 3'b010,
    CCS_ST_DONE  = 3'b100
  } ccs_state_t;

endpackage : ccs_pkg

// file: logic/ccs_word_fifo.sv
// file: input word fifo with variable limit and valid-word count
`timescale 1ns/1ps
module ccs_word_fifo
  import ccs_pkg::*;
(
  // clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 reset_in,
  input  wire logic                 clear_in,     // unit disabled: flush pointers
  // limit
  input  wire logic [4:0]           limit_in,     // current maximum number of words
  // fill side
  input  wire logic                 push_in,
  input  wire logic [CCS_DW-1:0]    push_data_in,
  // drain side
  input  wire logic                 pop_in,
  output logic      [CCS_DW-1:0]    pop_data_out,
  // status
  output ccs_fifo_stat_t            stat_out
);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [CCS_DW-1:0] mem_reg [CCS_DEPTH];   // word storage
  logic [3:0]        wr_ptr_reg;            // write pointer
  logic [3:0]        rd_ptr_reg;            // read pointer
  logic [4:0]        count_reg;             // valid words

  wire  full_w    = (count_reg >= limit_in);
  wire  empty_w   = (count_reg == 5'h00);
  wire  do_push_w = push_in && !full_w;     // a push onto a full fifo is dropped
  wire  do_pop_w  = pop_in && !empty_w;

  assign pop_data_out = mem_reg[rd_ptr_reg];
  assign stat_out     = '{fifo_word_count: count_reg,
                          fifo_full_flag:  full_w,
                          fifo_empty_flag: empty_w};

  // pointers and count; clear flushes them (rule one)
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      count_reg  <= 5'h00;
    end else if (clear_in) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      count_reg  <= 5'h00;
    end else begin
      if (do_push_w) wr_ptr_reg <= wr_ptr_reg + 4'h1;
      if (do_pop_w)  rd_ptr_reg <= rd_ptr_reg + 4'h1;
      count_reg <= count_reg + {4'h0, do_push_w} - {4'h0, do_pop_w};
    end
  end

  // storage writes, one generate entry per word
  genvar gi;
  generate
    for (gi = 0; gi < CCS_DEPTH; gi++) begin : g_word
      always_ff @(posedge mclk_in) begin
        if (do_push_w && (wr_ptr_reg == 4'(gi))) mem_reg[gi] <= push_data_in;
      end
    end
  endgenerate

endmodule : ccs_word_fifo

// file: logic/ccs_shifter.sv
// file: serial crc shifter, one data bit per clock
`timescale 1ns/1ps
module ccs_shifter
  import ccs_pkg::*;
(
  // clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 reset_in,
  input  wire logic                 clear_in,      // unit disabled: reset state
  // control
  input  wire logic                 step_in,       // shift allowed this cycle
  input  wire logic                 lsb_first_in,  // bit order of each word
  input  wire logic [4:0]           poly_length_field_in,       // polynomial length minus one
  input  wire logic [CCS_DW-1:0]    poly_in,       // feedback taps
  // word source
  input  wire logic                 word_avail_in,
  input  wire logic [CCS_DW-1:0]    word_in,
  output logic                      word_take_out,
  // result
  output logic                      busy_out,
  output logic      [CCS_DW-1:0]    crc_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ccs_state_t        state_reg;
  logic [3:0]        bit_reg;       // bits shifted of current word
  logic [CCS_DW-1:0] word_reg;      // word being shifted
  logic [CCS_DW-1:0] crc_reg;

  wire  [3:0] idx_w    = lsb_first_in ? bit_reg : (4'hF - bit_reg);
  wire        din_w    = word_reg[idx_w];
  wire        fb_w     = din_w ^ crc_reg[poly_length_field_in[3:0]];
  wire  [CCS_DW-1:0] crc_next = {crc_reg[CCS_DW-2:0], 1'b0} ^ (fb_w ? poly_in : '0);
  wire        load_w   = step_in && word_avail_in &&
                         (state_reg != CCS_ST_SHIFT);

  assign word_take_out = load_w;
  assign busy_out      = (state_reg == CCS_ST_SHIFT);
  assign crc_out       = crc_reg;

  // word load and serial shift
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= CCS_ST_IDLE;
      bit_reg   <= 4'h0;
      word_reg  <= '0;
      crc_reg   <= '0;
    end else if (clear_in) begin
      state_reg <= CCS_ST_IDLE;
      bit_reg   <= 4'h0;
      word_reg  <= '0;
      crc_reg   <= '0;
    end else begin
      case (state_reg)
        CCS_ST_IDLE, CCS_ST_DONE: begin
          if (load_w) begin
            word_reg  <= word_in;
            bit_reg   <= 4'h0;
            state_reg <= CCS_ST_SHIFT;
          end
        end
        CCS_ST_SHIFT: begin
          if (step_in) begin
            crc_reg <= crc_next;
            bit_reg <= bit_reg + 4'h1;
            if ({1'b0, bit_reg} == CCS_SHIFT_LAST) state_reg <= CCS_ST_DONE;
          end
        end
        default: state_reg <= CCS_ST_IDLE;
      endcase
    end
  end

endmodule : ccs_shifter

// file: logic/ccs_crc_ctrl.sv
// file: top of the crc control and status block with its register port
`timescale 1ns/1ps
// Notes on behaviour
// - enable low resets fifo, shifter, data, result
// - halt-in-idle set stops unit during idle
// - bits 12..8 report fifo valid-word count
// - depth 16 if length <=7, else 8
// - bit 7 reads one when fifo full
// - bit 6 reads one when fifo empty
// - select one: interrupt when fifo goes empty
// - select zero: interrupt when shifting completes
// - run bit starts shifter, zero stops it
// - bit 3 is read-write bit-order select
// - one shifts lsb first, zero msb first
// - low byte resets: full 0, empty 1, rest 0
// - bit 14 reads zero, ignores writes
module ccs_crc_ctrl
  import ccs_pkg::*;
(
  // clock and reset
  input  wire logic               mclk_in,
  input  wire logic               reset_in,
  // device power state
  input  wire logic               idle_mode_in,   // device in idle power mode
  // register port
  input  wire logic [3:0]         addr_in,
  input  wire logic [15:0]        wdata_in,
  input  wire logic               wr_in,
  input  wire logic               rd_in,
  output logic      [15:0]        rdata_out,
  // interrupt
  output logic                    irq_out
);

  // ----------------------------------------------------------------
  // idle input synchroniser
  // ----------------------------------------------------------------
  logic idle_meta_reg;   // first stage, read only by the second
  logic idle_sync_reg;   // safe idle level

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      idle_meta_reg <= 1'b0;
      idle_sync_reg <= 1'b0;
    end else begin
      idle_meta_reg <= idle_mode_in;
      idle_sync_reg <= idle_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  ccs_ctrl_t         ctrl_reg;       // writable bits of crc_control_one
  logic [4:0]        poly_length_field_reg;       // poly_length_field
  logic [CCS_DW-1:0] poly_reg;       // feedback taps
  logic [CCS_DW-1:0] result_word_reg;
  logic [1:0]        irq_stat_reg;   // sticky events
  logic [1:0]        irq_mask_reg;   // event enables
  logic [15:0]       rdata_reg;
  logic              irq_reg;
  logic              empty_d_reg;    // fifo empty one cycle ago
  logic              busy_d_reg;     // shifter busy one cycle ago

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire wr_ctrl_w   = wr_in && (addr_in == CCS_ADDR_CTRL1);
  wire wr_poly_length_field_w   = wr_in && (addr_in == CCS_ADDR_POLY_LENGTH_FIELD);
  wire wr_data_w   = wr_in && (addr_in == CCS_ADDR_DATA);
  wire wr_stat_w   = wr_in && (addr_in == CCS_ADDR_IRQ_ST);
  wire wr_mask_w   = wr_in && (addr_in == CCS_ADDR_IRQ_MSK);

  // ----------------------------------------------------------------
  // unit gating
  // ----------------------------------------------------------------
  wire clear_w   = !ctrl_reg.unit_on;
  wire halted_w  = ctrl_reg.halt_in_idle && idle_sync_reg;
  wire step_w    = ctrl_reg.unit_on && !halted_w &&
                   ctrl_reg.shifter_run;
  wire [4:0] limit_w = (poly_length_field_reg <= CCS_POLY_LENGTH_FIELD_SPLIT) ?
                       CCS_DEPTH_LONG : CCS_DEPTH_SHORT;

  // ----------------------------------------------------------------
  // input fifo and shifter
  // ----------------------------------------------------------------
  ccs_fifo_stat_t    fstat_w;
  logic [CCS_DW-1:0] fifo_word_w;
  logic              take_w;
  logic              busy_w;
  logic [CCS_DW-1:0] crc_w;

  ccs_word_fifo u_fifo (
    .mclk_in      (mclk_in),
    .reset_in     (reset_in),
    .clear_in     (clear_w),
    .limit_in     (limit_w),
    .push_in      (wr_data_w && ctrl_reg.unit_on),
    .push_data_in (wdata_in),
    .pop_in       (take_w),
    .pop_data_out (fifo_word_w),
    .stat_out     (fstat_w)
  );

  ccs_shifter u_shift (
    .mclk_in       (mclk_in),
    .reset_in      (reset_in),
    .clear_in      (clear_w),
    .step_in       (step_w),
    .lsb_first_in  (ctrl_reg.lsb_first_select),
    .poly_length_field_in       (poly_length_field_reg),
    .poly_in       (poly_reg),
    .word_avail_in (!fstat_w.fifo_empty_flag),
    .word_in       (fifo_word_w),
    .word_take_out (take_w),
    .busy_out      (busy_w),
    .crc_out       (crc_w)
  );

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  wire ev_empty_w = fstat_w.fifo_empty_flag && !empty_d_reg;     // fifo just drained
  wire ev_done_w  = !busy_w && busy_d_reg && ctrl_reg.unit_on && // a flush is no result
                    fstat_w.fifo_empty_flag;                     // all shifting over
  wire [1:0] ev_w = {ev_done_w, ev_empty_w};
  // the select bit routes one event to the interrupt line
  wire [1:0] sel_w = ctrl_reg.irq_source_select ? 2'b01 : 2'b10;
  wire irq_next   = |(irq_stat_reg & irq_mask_reg & sel_w);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [15:0] ctrl_rd_w = {ctrl_reg.unit_on,
                           1'b0,
                           ctrl_reg.halt_in_idle,
                           fstat_w.fifo_word_count,
                           fstat_w.fifo_full_flag,
                           fstat_w.fifo_empty_flag,
                           ctrl_reg.irq_source_select,
                           ctrl_reg.shifter_run,
                           ctrl_reg.lsb_first_select,
                           3'b000};
  wire [15:0] rd_mux_w =
    (addr_in == CCS_ADDR_CTRL1)   ? ctrl_rd_w :
    (addr_in == CCS_ADDR_POLY_LENGTH_FIELD)    ? {11'h000, poly_length_field_reg} :
    (addr_in == CCS_ADDR_RESULT)  ? result_word_reg :
    (addr_in == CCS_ADDR_IRQ_ST)  ? {14'h0000, irq_stat_reg} :
    (addr_in == CCS_ADDR_IRQ_MSK) ? {14'h0000, irq_mask_reg} :
    16'h0000;                                                    // unmapped reads zero

  // control register: only writable bits are stored
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_reg <= '0;
    end else if (wr_ctrl_w) begin
      ctrl_reg.unit_on           <= wdata_in[CCS_BIT_UNIT_ON];
      ctrl_reg.halt_in_idle      <= wdata_in[CCS_BIT_HALT_IDLE];
      ctrl_reg.irq_source_select <= wdata_in[CCS_BIT_IRQ_SEL];
      ctrl_reg.shifter_run       <= wdata_in[CCS_BIT_RUN];
      ctrl_reg.lsb_first_select  <= wdata_in[CCS_BIT_LSB_FIRST];
      // count, full and empty bits of wdata are dropped
    end
  end

  // length and taps keep their value while disabled
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      poly_length_field_reg <= CCS_RST_POLY_LENGTH_FIELD;
      poly_reg <= '0;
    end else if (wr_poly_length_field_w) begin
      poly_length_field_reg <= wdata_in[4:0];
    end
  end

  // result holder, cleared while disabled
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      result_word_reg <= '0;
    end else if (clear_w) begin
      result_word_reg <= '0;
    end else if (ev_done_w) begin
      result_word_reg <= crc_w;
    end
  end

  // sticky events: a new event beats a same-cycle clear
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_stat_reg <= CCS_RST_IRQ;
      irq_mask_reg <= CCS_RST_IRQ;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_stat_w ? wdata_in[1:0] : 2'b00)) | ev_w;
      if (wr_mask_w) irq_mask_reg <= wdata_in[1:0];
    end
  end

  // edge history, read data and interrupt line
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      empty_d_reg <= 1'b1;
      busy_d_reg  <= 1'b0;
      rdata_reg   <= 16'h0000;
      irq_reg     <= 1'b0;
    end else begin
      empty_d_reg <= fstat_w.fifo_empty_flag;
      busy_d_reg  <= busy_w;
      rdata_reg   <= rd_in ? rd_mux_w : 16'h0000;
      irq_reg     <= irq_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign irq_out   = irq_reg;

endmodule : ccs_crc_ctrl

// file: tb/ccs_crc_ctrl_properties.sv
// checker: port-level properties of the crc control and status block
`timescale 1ns/1ps
module ccs_crc_ctrl_properties
  import ccs_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  // device power state
  input  wire logic        idle_mode_in,
  // register port
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [15:0] rdata_out,
  // interrupt
  input  wire logic        irq_out
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic       ctrl_rd_reg;  // control read data stand in this cycle
  logic       mask_wr;      // write to the mask register
  logic [4:0] cnt;          // valid-word count field of the read data
  assign mask_wr = wr_in && (addr_in == CCS_ADDR_IRQ_MSK);
  assign cnt     = rdata_out[CCS_BIT_CNT_HI:CCS_BIT_CNT_LO];
  // remember for one cycle that the control register was read
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_rd_reg <= 1'b0;
    end else begin
      ctrl_rd_reg <= rd_in && (addr_in == CCS_ADDR_CTRL1);
    end
  end
  default clocking dflt_cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // a settled disabled unit shows an empty fifo
  chk_off_flushed: assert property (ctrl_rd_reg && !rdata_out[15] && !$past(wr_in, 2)
    && !$past(wr_in, 3) |-> cnt == 5'h00 && rdata_out[CCS_BIT_EMPTY])
    else $error("disabled unit still reports fifo words");
  chk_bit14_zero: assert property (ctrl_rd_reg |-> !rdata_out[14])
    else $error("unimplemented bit 14 read as one");
  chk_low_bits_zero: assert property (ctrl_rd_reg |-> rdata_out[2:0] == 3'h0)
    else $error("unused low bits read nonzero");
  chk_empty_count: assert property (ctrl_rd_reg |-> rdata_out[CCS_BIT_EMPTY] == (cnt == 5'h00))
    else $error("empty flag disagrees with word count");
  chk_count_limit: assert property (ctrl_rd_reg |-> cnt <= 5'h10)
    else $error("word count above deepest fifo");
  chk_full_count: assert property (ctrl_rd_reg && rdata_out[CCS_BIT_FULL] |-> cnt >= 5'h08)
    else $error("full flag with fewer than eight words");
  chk_full_at_top: assert property (ctrl_rd_reg && cnt == 5'h10 |-> rdata_out[CCS_BIT_FULL])
    else $error("sixteen words without full flag");
  chk_irq_masked: assert property ((mask_wr && wdata_in[1:0] == 2'h0) ##1 !mask_wr
    |-> ##1 !irq_out)
    else $error("interrupt high with all events masked");
endmodule : ccs_crc_ctrl_properties

// file: tb/ccs_crc_ctrl_bench.sv
// testbench: register-level regression of the crc control and status block
`timescale 1ns/1ps
module ccs_crc_ctrl_bench
  import ccs_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        mclk_in;       // 25 MHz clock
  logic        reset_in;      // async reset, high
  logic        idle_mode_in;  // device idle power mode
  logic [3:0]  addr_in;       // register address
  logic [15:0] wdata_in;      // write data
  logic        wr_in;         // write strobe
  logic        rd_in;         // read strobe
  logic [15:0] rdata_out;     // read data
  logic        irq_out;       // level interrupt
  int          err_count;     // mismatches
  int          comparisons;   // compares made
  logic [15:0] rd_val;        // last read data
  int          i;             // loop index
  ccs_crc_ctrl ccs_crc_ctrl_inst (.mclk_in(mclk_in), .reset_in(reset_in),
    .idle_mode_in(idle_mode_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out));
  // clock generator
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one write cycle
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr_reg
  // one read cycle, data taken in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    rd_val = rdata_out;
  endtask : rd_reg
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string name);
    rd_reg(a);
    check(name, rd_val, exp);
  endtask : rd_chk
  // poll the status register until an event bit sets, bounded
  task automatic wait_ev(input int b);
    int n;
    n = 0;
    rd_reg(CCS_ADDR_IRQ_ST);
    while (rd_val[b] !== 1'b1 && n < 60) begin
      rd_reg(CCS_ADDR_IRQ_ST);
      n++;
    end
    check("event bit", {15'h0000, rd_val[b]}, 16'h0001);
  endtask : wait_ev
  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge mclk_in);
    #1;
    check("irq level", {15'h0000, irq_out}, {15'h0000, exp});
  endtask : chk_irq
  // expected control word for n pushes into a fifo of lim words
  function automatic logic [15:0] exp_ctrl(input logic [15:0] base, input int n, input int lim);
    int c;
    c = (n > lim) ? lim : n;
    return base | (16'(c) << 8) | ((c == lim) ? 16'h0080 : 16'h0000)
      | ((c == 0) ? 16'h0040 : 16'h0000);
  endfunction : exp_ctrl
  task automatic close_out();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_count++;
    close_out();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    reset_in = 1'b1;
    idle_mode_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 16'h0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    rd_chk(CCS_ADDR_CTRL1, 16'h0040, "ctrl reset");
    rd_chk(CCS_ADDR_IRQ_MSK, 16'h0000, "mask reset");
    rd_chk(4'hF, 16'h0000, "unmapped read");
    wr_reg(CCS_ADDR_CTRL1, 16'h7FFF);
    rd_chk(CCS_ADDR_CTRL1, 16'h2078, "ctrl write");
    wr_reg(CCS_ADDR_CTRL1, 16'h0000);
    rd_chk(CCS_ADDR_CTRL1, 16'h0040, "ctrl clear");
    $display("test register access done");
    // fill past the top with the shifter stopped; length 7 keeps the deep fifo
    rd_chk(CCS_ADDR_POLY_LENGTH_FIELD, {11'h000, CCS_RST_POLY_LENGTH_FIELD}, "length reset");
    wr_reg(CCS_ADDR_POLY_LENGTH_FIELD, 16'h0007);
    wr_reg(CCS_ADDR_CTRL1, 16'h8000);
    for (i = 1; i <= 17; i++) begin
      wr_reg(CCS_ADDR_DATA, 16'hA5C3 + 16'(i));
      rd_chk(CCS_ADDR_CTRL1, exp_ctrl(16'h8000, i, 16), "fill 16");
    end
    // long length field halves the depth; disabling flushes
    wr_reg(CCS_ADDR_POLY_LENGTH_FIELD, 16'h0008);
    wr_reg(CCS_ADDR_CTRL1, 16'h0020);
    rd_chk(CCS_ADDR_POLY_LENGTH_FIELD, 16'h0008, "length kept");
    rd_chk(CCS_ADDR_CTRL1, 16'h0060, "flushed");
    wr_reg(CCS_ADDR_CTRL1, 16'h8000);
    for (i = 1; i <= 9; i++) begin
      wr_reg(CCS_ADDR_DATA, 16'h3C00 + 16'(i));
      rd_chk(CCS_ADDR_CTRL1, exp_ctrl(16'h8000, i, 8), "fill 8");
    end
    wr_reg(CCS_ADDR_CTRL1, 16'h0000);
    wr_reg(CCS_ADDR_POLY_LENGTH_FIELD, 16'h000F);
    $display("test fifo depth done");
    // interrupt as the fifo empties, lsb first
    wr_reg(CCS_ADDR_IRQ_MSK, 16'h0003);
    wr_reg(CCS_ADDR_IRQ_ST, 16'h0003);
    wr_reg(CCS_ADDR_CTRL1, 16'h8038);
    chk_irq(1'b0);
    wr_reg(CCS_ADDR_DATA, 16'h1234);
    chk_irq(1'b1);
    rd_chk(CCS_ADDR_IRQ_ST, 16'h0001, "early event");
    wait_ev(1);
    // interrupt only once shifting is over, msb first
    wr_reg(CCS_ADDR_CTRL1, 16'h8010);
    wr_reg(CCS_ADDR_IRQ_ST, 16'h0003);
    chk_irq(1'b0);
    wr_reg(CCS_ADDR_DATA, 16'h8001);
    chk_irq(1'b0);
    wait_ev(1);
    chk_irq(1'b1);
    wr_reg(CCS_ADDR_IRQ_MSK, 16'h0000);
    chk_irq(1'b0);
    wr_reg(CCS_ADDR_IRQ_MSK, 16'h0003);
    chk_irq(1'b1);
    wr_reg(CCS_ADDR_IRQ_ST, 16'h0003);
    chk_irq(1'b0);
    $display("test interrupt select done");
    // halt in idle holds shifting until idle ends
    @(posedge mclk_in);
    idle_mode_in <= 1'b1;
    wr_reg(CCS_ADDR_CTRL1, 16'hA010);
    wr_reg(CCS_ADDR_DATA, 16'h00FF);
    repeat (30) @(posedge mclk_in);
    rd_reg(CCS_ADDR_IRQ_ST);
    check("idle halt", {15'h0000, rd_val[1]}, 16'h0000);
    @(posedge mclk_in);
    idle_mode_in <= 1'b0;
    wait_ev(1);
    // without halt the shifter runs on in idle
    wr_reg(CCS_ADDR_IRQ_ST, 16'h0003);
    idle_mode_in <= 1'b1;
    wr_reg(CCS_ADDR_CTRL1, 16'h8010);
    wr_reg(CCS_ADDR_DATA, 16'h0F0F);
    wait_ev(1);
    $display("test idle mode done");
    close_out();
  end
endmodule : ccs_crc_ctrl_bench

bind ccs_crc_ctrl ccs_crc_ctrl_properties ccs_crc_ctrl_properties_inst (.mclk_in(mclk_in),
  .reset_in(reset_in), .idle_mode_in(idle_mode_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out));
